// ==== logic/reset_mode_ctrl.sv ====
// reset merge, clock multiplier mode and core hold controller
`timescale 1ns/1ps
module reset_mode_ctrl
  import reset_ctl_pkg::*;
#(
  parameter int SETTLE_LEN = SETTLE_CYCLES,
  parameter int CNT_WIDTH = SETTLE_WIDTH
)
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic ext_reset_in,
  input wire logic mode_request_write_in,
  input wire logic mode_request_in,
  input wire logic soft_reset_in,
  input wire logic gpio_oe_write_in,
  input wire logic [reset_ctl_pkg::GPIO_COUNT-1:0] gpio_oe_in,
  input wire logic [reset_ctl_pkg::DIV_WIDTH-1:0] baud_divisor_in,
  input wire logic [reset_ctl_pkg::DIV_WIDTH-1:0] tone_divisor_in,
  output logic core_reset_out,
  output logic pll_enable_out,
  output logic mode_request_out,
  output logic [3:0] clock_ratio_out,
  output logic main_tick_out,
  output logic [reset_ctl_pkg::GPIO_COUNT-1:0] gpio_oe_out,
  output logic baud_tick_out,
  output logic tone_out
);
  import reset_ctl_pkg::*;

  localparam logic [CNT_WIDTH-1:0] SETTLE_LAST = CNT_WIDTH'(SETTLE_LEN - 1);

  typedef struct packed
  {
    phase_e phase;
    logic [CNT_WIDTH-1:0] count;
    logic pll_mode;
    logic request;
    logic core_reset;
    logic [GPIO_COUNT-1:0] gpio_oe;
  } ctrl_s;

  ctrl_s state;
  ctrl_s next_state;

  logic any_reset;
  logic main_tick;
  logic baud_pulse;
  logic tone_wave;

  // ==========================================================
  // reset merge
  // the supply monitor drives reset_in, so no board circuit is needed
  assign any_reset = ext_reset_in || soft_reset_in; // RULE1

  // ==========================================================
  // next state
  always_comb
  begin
    next_state = state;
    if (ext_reset_in)
    begin
      // pin reset behaves as power-up: mode back to multiplier on
      next_state.phase = SETTLE; // RULE2
      next_state.count = '0;
      next_state.pll_mode = PLL_MODE_ON; // RULE8
      next_state.request = PLL_MODE_ON;
      next_state.core_reset = 1'b1;
      next_state.gpio_oe = GPIO_OE_RESET; // RULE10
    end
    else if (soft_reset_in)
    begin
      // the request written earlier is applied only here
      next_state.phase = SETTLE; // RULE7
      next_state.count = '0;
      next_state.pll_mode = state.request; // RULE8
      next_state.core_reset = 1'b1;
      next_state.gpio_oe = GPIO_OE_RESET; // RULE10
    end
    else
    begin
      if (mode_request_write_in)
        next_state.request = mode_request_in; // RULE7
      case (state.phase)
        SETTLE:
        begin
          // counted on the crystal clock, which is steady during the switch
          next_state.core_reset = 1'b1; // RULE5
          next_state.gpio_oe = GPIO_OE_RESET;
          if (state.count >= SETTLE_LAST) // RULE11
          begin
            next_state.phase = RUN;
            next_state.core_reset = 1'b0;
          end
          else
            next_state.count = state.count + 1'b1;
        end
        RUN:
        begin
          // mode is left untouched while the core runs
          next_state.core_reset = 1'b0; // RULE4
          if (gpio_oe_write_in)
            next_state.gpio_oe = gpio_oe_in; // RULE10
        end
        default:
        begin
          next_state.phase = SETTLE;
          next_state.count = '0;
          next_state.core_reset = 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      state.phase <= SETTLE;
      state.count <= '0;
      state.pll_mode <= PLL_MODE_ON; // RULE6
      state.request <= PLL_MODE_ON;
      state.core_reset <= 1'b1; // RULE1
      state.gpio_oe <= GPIO_OE_RESET; // RULE10
    end
    else
      state <= next_state;
  end

  // ==========================================================
  // derived clocks
  main_tick_gen u_main_tick
  (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .pll_mode_in(state.pll_mode),
    .tick_out(main_tick)
  );

  // both dividers count main ticks, so they follow the mode
  rate_divider #(.WIDTH(DIV_WIDTH)) u_baud
  (
    .clk_in(clk_in),
    .reset_in(state.core_reset),
    .tick_in(main_tick),
    .divisor_in(baud_divisor_in),
    .pulse_out(baud_pulse),
    .wave_out()
  ); // RULE9

  rate_divider #(.WIDTH(DIV_WIDTH)) u_tone
  (
    .clk_in(clk_in),
    .reset_in(state.core_reset),
    .tick_in(main_tick),
    .divisor_in(tone_divisor_in),
    .pulse_out(),
    .wave_out(tone_wave)
  ); // RULE9

  // ==========================================================
  // outputs
  assign core_reset_out = state.core_reset;
  assign pll_enable_out = state.pll_mode;
  assign mode_request_out = state.request;
  assign clock_ratio_out = state.pll_mode ? RATIO_ON : RATIO_OFF; // RULE3
  assign main_tick_out = main_tick;
  assign gpio_oe_out = state.gpio_oe;
  assign baud_tick_out = baud_pulse;
  assign tone_out = tone_wave;

  // ==========================================================
  // checks
  sequence reset_entry;
    any_reset && !reset_in;
  endsequence

  sequence settle_done;
    $fell(core_reset_out);
  endsequence

  a_power_up_mode: assert property (@(posedge clk_in) // RULE6
    reset_in |=> pll_enable_out && core_reset_out && mode_request_out)
    else $error("power-up did not select multiplier on");

  a_pin_reset: assert property (@(posedge clk_in) disable iff (reset_in) // RULE2
    ext_reset_in |=> pll_enable_out && core_reset_out)
    else $error("pin reset did not restore power-up state");

  a_soft_mode: assert property (@(posedge clk_in) disable iff (reset_in) // RULE8
    (soft_reset_in && !ext_reset_in) |=> pll_enable_out == $past(mode_request_out))
    else $error("internal reset did not apply requested mode");

  a_mode_hold: assert property (@(posedge clk_in) disable iff (reset_in) // RULE4
    !any_reset |=> $stable(pll_enable_out))
    else $error("mode changed without reset");

  a_request_keep: assert property (@(posedge clk_in) disable iff (reset_in) // RULE7
    (mode_request_write_in && !any_reset) |=> mode_request_out == $past(mode_request_in))
    else $error("mode request not stored");

  a_settle_hold: assert property (@(posedge clk_in) disable iff (reset_in) // RULE5
    reset_entry |=> core_reset_out [*8])
    else $error("core released before settling");

  a_settle_length: assert property (@(posedge clk_in) disable iff (reset_in) // RULE11
    settle_done |-> $past(state.count) == SETTLE_LAST)
    else $error("settle count length wrong");

  a_gpio_off: assert property (@(posedge clk_in) disable iff (reset_in) // RULE10
    $past(core_reset_out) && core_reset_out |-> gpio_oe_out == GPIO_OE_RESET)
    else $error("output buffer enabled during reset");

  // the first cycle after switching off may still follow a full-rate tick
  a_ratio_mode: assert property (@(posedge clk_in) disable iff (reset_in) // RULE3
    !pll_enable_out |-> clock_ratio_out == RATIO_OFF
      && !(main_tick_out && $past(main_tick_out) && !$past(pll_enable_out)))
    else $error("main rate wrong for multiplier off");

  // divisor zero at full rate gives a pulse on every cycle, so the rate follows the mode
  a_baud_scaled: assert property (@(posedge clk_in) disable iff (reset_in) // RULE9
    $past(pll_enable_out) && !$past(core_reset_out) && $past(baud_divisor_in) == '0
      |-> baud_tick_out)
    else $error("baud pulse missing at full rate");

  // ==========================================================
  // checks: settling timeline
  // the count is only visible inside, so these look at the state directly
  sequence settle_counting;
    state.phase == SETTLE && !any_reset && state.count < SETTLE_LAST;
  endsequence

  sequence settle_last;
    state.phase == SETTLE && !any_reset && state.count == SETTLE_LAST;
  endsequence

  a_settle_clear: assert property (@(posedge clk_in) disable iff (reset_in) // RULE5
    reset_entry |=> state.phase == SETTLE && state.count == '0)
    else $error("reset did not restart settling count");

  a_settle_step: assert property (@(posedge clk_in) disable iff (reset_in) // RULE11
    settle_counting |=> core_reset_out && state.count == $past(state.count) + 1'b1)
    else $error("settling count did not advance");

  // the hold ends exactly on the last count, never earlier or later
  a_release_edge: assert property (@(posedge clk_in) disable iff (reset_in) // RULE5
    settle_last |=> state.phase == RUN && !core_reset_out)
    else $error("core not released after settling");

  // once running, only a reset may bring the core back into the hold
  a_run_stays: assert property (@(posedge clk_in) disable iff (reset_in) // RULE4
    state.phase == RUN && !any_reset |=> state.phase == RUN && !core_reset_out)
    else $error("core left running state without reset");

  // ==========================================================
  // checks: mode request and output buffers
  a_request_hold: assert property (@(posedge clk_in) disable iff (reset_in) // RULE7
    !mode_request_write_in && !ext_reset_in |=> $stable(mode_request_out))
    else $error("mode request changed without a write");

  a_ext_request: assert property (@(posedge clk_in) disable iff (reset_in) // RULE2
    ext_reset_in |=> mode_request_out && gpio_oe_out == GPIO_OE_RESET)
    else $error("pin reset left request or buffers set");

  // an internal reset must not lose the request it is about to apply
  a_soft_request: assert property (@(posedge clk_in) disable iff (reset_in) // RULE8
    soft_reset_in && !ext_reset_in
      |=> $stable(mode_request_out) && gpio_oe_out == GPIO_OE_RESET)
    else $error("internal reset lost request or left buffers set");

  a_gpio_write: assert property (@(posedge clk_in) disable iff (reset_in) // RULE10
    gpio_oe_write_in && !core_reset_out && !any_reset |=> gpio_oe_out == $past(gpio_oe_in))
    else $error("output enable write not taken");

  // a buffer never turns on by itself, only by an explicit write
  a_gpio_hold: assert property (@(posedge clk_in) disable iff (reset_in) // RULE10
    !gpio_oe_write_in && !any_reset |=> $stable(gpio_oe_out))
    else $error("output enables changed without a write");

  // ==========================================================
  // checks: derived rates
  a_ratio_on: assert property (@(posedge clk_in) disable iff (reset_in) // RULE3
    pll_enable_out |-> clock_ratio_out == RATIO_ON)
    else $error("ratio wrong for multiplier on");

  // the dividers clear one cycle after the hold starts and stay quiet
  a_divider_quiet: assert property (@(posedge clk_in) disable iff (reset_in) // RULE9
    core_reset_out && $past(core_reset_out) |-> !baud_tick_out && !tone_out)
    else $error("divider active while core held");

  // outside the hold the square wave only moves on a main tick, so it scales with the mode
  a_tone_hold: assert property (@(posedge clk_in) disable iff (reset_in) // RULE9
    !$past(main_tick_out) && !$past(core_reset_out) |-> $stable(tone_out))
    else $error("square wave moved without main tick");

  a_baud_follows: assert property (@(posedge clk_in) disable iff (reset_in) // RULE9
    baud_tick_out |-> $past(main_tick_out))
    else $error("baud pulse without main tick");

endmodule

// ==== logic/reset_ctl_pkg.sv ====
// constants shared by the reset and clock mode controller
// ==========================================================
// Functional notes
// RULE1 - supply-monitor reset alone restarts the block; no outside circuit needed
// RULE2 - external reset pin is active high; tied low means normal running
// RULE3 - main clock runs at crystal rate with multiplier off, eight times with it on
// RULE4 - multiplier mode never changes while running, only as part of a reset
// RULE5 - core stays in reset after every reset until the multiplier has settled
// RULE6 - power-up always selects multiplier on; no pin chooses the mode
// RULE7 - software reads mode, writes a request, then triggers an internal reset
// RULE8 - internal reset equals other resets except mode takes the software request
// RULE9 - baud ticks and square wave are derived from the main clock rate
// RULE10 - every I/O output buffer is off after reset until software enables it
// RULE11 - settling hold is a crystal-clocked counter whose length is a parameter
package reset_ctl_pkg;

  // ==========================================================
  // clock and timing
  localparam int CLK_PERIOD_NS = 5;
  // settling time of the multiplier, a plain default since none is fixed
  localparam int SETTLE_TIME_NS = 5120;
  localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_WIDTH = 16;

  // ==========================================================
  // clock multiplier
  localparam int MULT_RATIO = 8;
  localparam logic [2:0] MULT_LAST = 3'h7;
  localparam logic [3:0] RATIO_OFF = 4'h1;
  localparam logic [3:0] RATIO_ON = 4'h8;
  localparam logic PLL_MODE_ON = 1'b1;
  localparam logic PLL_MODE_OFF = 1'b0;

  // ==========================================================
  // i/o and dividers
  localparam int GPIO_COUNT = 32;
  localparam int DIV_WIDTH = 16;
  localparam logic [31:0] GPIO_OE_RESET = 32'h0000_0000;

  typedef enum {SETTLE, RUN} phase_e;

endpackage

// ==== logic/main_tick_gen.sv ====
// main clock strobe: every crystal cycle with multiplier on, every eighth with it off
`timescale 1ns/1ps
module main_tick_gen
  import reset_ctl_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic pll_mode_in,
  output logic tick_out
);
  import reset_ctl_pkg::*;

  typedef struct packed
  {
    logic [2:0] phase;
  } tick_s;

  tick_s state;
  tick_s next_state;

  // ==========================================================
  // strobe
  always_comb
  begin
    next_state = state;
    next_state.phase = state.phase + 3'h1;
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      state <= '0;
    else
      state <= next_state;
  end

  // the slow rate is one in eight so derived rates scale exactly
  assign tick_out = pll_mode_in || (state.phase == MULT_LAST); // RULE3

  a_slow_rate: assert property (@(posedge clk_in) disable iff (reset_in) // RULE3
    (!pll_mode_in && tick_out) ##1 !pll_mode_in |-> !tick_out)
    else $error("slow main tick came early");

endmodule

// ==== logic/rate_divider.sv ====
// divides the main clock strobe into a pulse and a square wave
`timescale 1ns/1ps
module rate_divider
  import reset_ctl_pkg::*;
#(
  parameter int WIDTH = DIV_WIDTH
)
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic tick_in,
  input wire logic [WIDTH-1:0] divisor_in,
  output logic pulse_out,
  output logic wave_out
);
  import reset_ctl_pkg::*;

  typedef struct packed
  {
    logic [WIDTH-1:0] count;
    logic pulse;
    logic wave;
  } div_s;

  div_s state;
  div_s next_state;

  // ==========================================================
  // divider
  always_comb
  begin
    next_state = state;
    next_state.pulse = 1'b0;
    if (tick_in) // RULE9
    begin
      if (state.count >= divisor_in)
      begin
        next_state.count = '0;
        next_state.pulse = 1'b1;
        next_state.wave = !state.wave;
      end
      else
        next_state.count = state.count + 1'b1;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      state <= '0;
    else
      state <= next_state;
  end

  assign pulse_out = state.pulse;
  assign wave_out = state.wave;

  a_pulse_on_tick: assert property (@(posedge clk_in) disable iff (reset_in) // RULE9
    pulse_out |-> $past(tick_in))
    else $error("divider pulse without main tick");

endmodule

// ==== bench/reset_and_pll_mode_control_bench.sv ====
// self-checking bench for the reset merge and clock multiplier mode controller
`timescale 1ns/1ps
module reset_and_pll_mode_control_bench;
  import reset_ctl_pkg::*;
  // ==========================================================
  // stimulus and design
  // short settling hold keeps the run brief; all expectations use it
  localparam int HOLD = 12;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic ext_reset_in = 1'b0;
  logic mode_request_write_in = 1'b0;
  logic mode_request_in = 1'b0;
  logic soft_reset_in = 1'b0;
  logic gpio_oe_write_in = 1'b0;
  logic [GPIO_COUNT-1:0] gpio_oe_in = 32'h0;
  logic [DIV_WIDTH-1:0] baud_divisor_in = 16'h0;
  logic [DIV_WIDTH-1:0] tone_divisor_in = 16'h0;
  logic core_reset_out;
  logic pll_enable_out;
  logic mode_request_out;
  logic [3:0] clock_ratio_out;
  logic main_tick_out;
  logic [GPIO_COUNT-1:0] gpio_oe_out;
  logic baud_tick_out;
  logic tone_out;
  int err_count = 0;
  int comparisons = 0;

  reset_mode_ctrl #(.SETTLE_LEN(HOLD)) i_reset_mode_ctrl (.clk_in(clk_in), .reset_in(reset_in),
    .ext_reset_in(ext_reset_in), .mode_request_write_in(mode_request_write_in),
    .mode_request_in(mode_request_in), .soft_reset_in(soft_reset_in),
    .gpio_oe_write_in(gpio_oe_write_in), .gpio_oe_in(gpio_oe_in),
    .baud_divisor_in(baud_divisor_in), .tone_divisor_in(tone_divisor_in),
    .core_reset_out(core_reset_out), .pll_enable_out(pll_enable_out),
    .mode_request_out(mode_request_out), .clock_ratio_out(clock_ratio_out),
    .main_tick_out(main_tick_out), .gpio_oe_out(gpio_oe_out),
    .baud_tick_out(baud_tick_out), .tone_out(tone_out));

  // ==========================================================
  // helpers
  function automatic int exp_gap(input int d, input int m);
    return (d + 1) * (m ? 1 : MULT_RATIO);
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    begin
      comparisons++;
      if (seen !== exp)
      begin
        err_count++;
        $display("[ERR] %0t ns: saw %0h, expected %0h", $time, seen, exp);
      end
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // which: 0 supply reset, 1 pin reset, 2 internal reset
  task automatic do_reset(input int which, input int cycles);
    int n;
    begin
      if (which == 0)
        reset_in = 1'b1;
      else if (which == 1)
        ext_reset_in = 1'b1;
      else
        soft_reset_in = 1'b1;
      repeat (cycles) @(negedge clk_in);
      chk(core_reset_out, 1);
      chk(gpio_oe_out, 0);
      reset_in = 1'b0;
      ext_reset_in = 1'b0;
      soft_reset_in = 1'b0;
      mode_request_write_in = 1'b0;
      // a write while the core is held must be ignored
      gpio_oe_write_in = 1'b1;
      gpio_oe_in = 32'hFFFF_FFFF;
      @(negedge clk_in);
      gpio_oe_write_in = 1'b0;
      chk(gpio_oe_out, 0);
      n = 1;
      while (core_reset_out === 1'b1 && n < 200)
      begin
        @(negedge clk_in);
        n++;
      end
      chk(n, HOLD);
    end
  endtask

  // sel 0: cycles between baud pulses, sel 1: cycles between tone edges
  task automatic gap(input int sel, output int g);
    int k;
    int start;
    logic prev;
    logic ev;
    begin
      g = -1;
      start = -1;
      prev = tone_out;
      for (k = 0; k < 3000 && g < 0; k++)
      begin
        @(negedge clk_in);
        ev = sel ? (tone_out !== prev) : (baud_tick_out === 1'b1);
        prev = tone_out;
        if (ev && start >= 0)
          g = k - start;
        else if (ev)
          start = k;
      end
    end
  endtask

  // ==========================================================
  // clock and watchdog
  initial
  begin
    forever #2.5 clk_in = ~clk_in;
  end

  initial
  begin
    #100000;
    err_count++;
    end_sim();
  end

  // ==========================================================
  // main sequence
  initial
  begin : main
    int m;
    int n;
    int d;
    int sd;
    logic [31:0] v;
    v = $urandom(74009);
    do_reset(0, 20);
    chk(pll_enable_out, 1);
    chk(mode_request_out, 1);
    chk(clock_ratio_out, 8);
    // request meeting an internal reset in the same cycle is dropped
    mode_request_write_in = 1'b1;
    mode_request_in = 1'b0;
    do_reset(2, 1);
    chk(mode_request_out, 1);
    chk(pll_enable_out, 1);
    for (m = 0; m < 2; m++)
    begin
      // full rate with divisor zero is a corner the random range seldom hits
      d = m ? 0 : $urandom_range(6, 0);
      sd = $urandom_range(6, 0);
      baud_divisor_in = d[15:0];
      tone_divisor_in = sd[15:0];
      mode_request_write_in = 1'b1;
      mode_request_in = m[0];
      @(negedge clk_in);
      mode_request_write_in = 1'b0;
      chk(mode_request_out, m);
      // mode must not move while running
      repeat (5)
      begin
        @(negedge clk_in);
        chk(pll_enable_out, 1 - m);
      end
      do_reset(2, 1);
      chk(pll_enable_out, m);
      chk(mode_request_out, m);
      chk(clock_ratio_out, m ? 8 : 1);
      n = 0;
      repeat (64)
      begin
        @(negedge clk_in);
        n += main_tick_out ? 1 : 0;
      end
      chk(n, m ? 64 : 8);
      gap(0, n);
      chk(n, exp_gap(d, m));
      gap(1, n);
      chk(n, exp_gap(sd, m));
      v = $urandom;
      gpio_oe_write_in = 1'b1;
      gpio_oe_in = v;
      @(negedge clk_in);
      gpio_oe_write_in = 1'b0;
      chk(gpio_oe_out, v);
    end
    // pin reset after switching off: mode returns to on
    mode_request_write_in = 1'b1;
    mode_request_in = 1'b0;
    @(negedge clk_in);
    mode_request_write_in = 1'b0;
    do_reset(2, 1);
    chk(pll_enable_out, 0);
    do_reset(1, 3);
    chk(pll_enable_out, 1);
    chk(mode_request_out, 1);
    end_sim();
  end
endmodule
